// ---- prepit_pkg.sv ----
// Shared constants and types for the land pre-pit deframer.
package prepit_pkg;

	// Three-bit pre-pit symbols.
	localparam logic [2:0] SYM_SYNC_EVEN = 3'h7;
	localparam logic [2:0] SYM_SYNC_ODD = 3'h6;
	localparam logic [2:0] SYM_DATA_ONE = 3'h5;
	localparam logic [2:0] SYM_DATA_ZERO = 3'h4;
	localparam logic [1:0] SYM_SYNC_HEAD = 2'h3;
	localparam logic [1:0] SYM_DATA_HEAD = 2'h2;

	// Data frame layout: relative address then user byte, MSB first.
	localparam int REL_ADDR_BITS = 4;
	localparam int USER_BITS = 8;
	localparam int FRAME_BITS = 12;
	localparam int REL_ADDR_MSB = 11;
	localparam int REL_ADDR_LSB = 8;

	// Sync frame positions inside one sector of 13 symbols.
	localparam logic [4:0] POS_SYNC = 5'h00;
	localparam logic [4:0] POS_LAST_DATA = 5'h18;
	localparam logic [4:0] POS_LAST_FRAME = 5'h19;

	// Relative addresses inside one block of 16 frames.
	localparam logic [3:0] REL_FIRST = 4'h0;
	localparam logic [3:0] REL_ADDR_LAST = 4'h2;
	localparam logic [3:0] REL_PARITY_A_LAST = 4'h5;
	localparam logic [3:0] REL_CLASS = 4'h6;
	localparam logic [3:0] REL_INFO_FIRST = 4'h7;
	localparam logic [3:0] REL_INFO_LAST = 4'hc;
	localparam logic [3:0] REL_LAST = 4'hf;

	// Block content limits.
	localparam logic [7:0] CLASS_MAX = 8'h05;
	localparam logic [23:0] DATA_ZONE_START = 24'h003000;
	localparam logic [23:0] ADDR_STEP = 24'h000001;

	// Frame stream buffer depth.
	localparam int FIFO_DEPTH = 4;

	typedef enum logic [0:0] {
		ST_HUNT = 1'b0,
		ST_LOCKED = 1'b1
	} sector_state_t;

endpackage : prepit_pkg

// ---- frame_fifo_if.sv ----
// Valid/ready carrier between the deframer and its frame buffer.
`timescale 1ns/1ps
interface frame_fifo_if #(parameter int WIDTH = 12);
	logic wrValid;
	logic wrReady;
	logic [WIDTH-1:0] wrData;
	logic rdValid;
	logic rdReady;
	logic [WIDTH-1:0] rdData;

	modport store (
		input wrValid,
		output wrReady,
		input wrData,
		output rdValid,
		input rdReady,
		output rdData
	);
	modport user (
		output wrValid,
		input wrReady,
		output wrData,
		input rdValid,
		output rdReady,
		input rdData
	);
endinterface : frame_fifo_if

// ---- frame_fifo.sv ----
// Small synchronous FIFO for decoded data frames.
`timescale 1ns/1ps
module frame_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Buffer ports
	frame_fifo_if.store port
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr;
	logic [PW-1:0] rdPtr;
	logic [PW:0] count;
	logic doWrite;
	logic doRead;

	assign port.wrReady = (count != FULL_COUNT);
	assign port.rdValid = (count != '0);
	assign port.rdData = mem[rdPtr];
	assign doWrite = port.wrValid && port.wrReady;
	assign doRead = port.rdValid && port.rdReady;

	always_ff @(posedge clk) begin
		if (doWrite) begin
			mem[wrPtr] <= port.wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wrPtr <= '0;
		end else if (doWrite) begin
			wrPtr <= (wrPtr == LAST_SLOT) ? '0 : wrPtr + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rdPtr <= '0;
		end else if (doRead) begin
			rdPtr <= (rdPtr == LAST_SLOT) ? '0 : rdPtr + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count <= '0;
		end else if (doWrite && !doRead) begin
			count <= count + 1'b1;
		end else if (doRead && !doWrite) begin
			count <= count - 1'b1;
		end
	end

endmodule : frame_fifo

// ---- land_prepit_block_deframer.sv ----
// Land pre-pit deframer: symbols to frames, frames to checked blocks.
// Behaviour
// - Each symbol is three bits and one symbol comes per pair of sync frames.
// - A sector opens with a sync symbol, 111 for even and 110 for odd placement.
// - A symbol is only taken in the cycle that marks a groove sync frame.
// - Either even or odd placement is accepted, following the sector's sync.
// - A data frame is a 4-bit relative address followed by a user byte.
// - A sector is a sync symbol, 4 address symbols and 8 user data symbols.
// - A block is 16 data frames, one sector each.
// - Frames 0 to 5 hold three address bytes and three parity bytes.
// - Frames 6 to 15 hold the class code, six info bytes and three parity bytes.
// - The first part yields the block address, the second the classed information.
// - The class code runs 0 to 5 and a larger value is flagged.
// - Block addresses rise by one from block to block, data zone from 003000.
`timescale 1ns/1ps
module land_prepit_block_deframer
	import prepit_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Pre-pit detector
	input wire logic frameTick,
	input wire logic pitValid,
	input wire logic [2:0] pitBits,
	// Decoded frame stream
	output logic frameValid,
	input wire logic frameReady,
	output logic [11:0] frameData,
	output logic frameDropped,
	// Sector status
	output logic syncLocked,
	output logic sectorOdd,
	// Block results
	output logic blockDone,
	output logic [23:0] blockAddress,
	output logic [7:0] blockClassCode,
	output logic [47:0] blockInfo,
	output logic blockInDataZone,
	output logic blockOrderError,
	output logic blockSyncError,
	output logic blockSymbolError,
	output logic blockClassError,
	output logic blockStepError
);
	frame_fifo_if #(.WIDTH(FRAME_BITS)) fifoBus ();

	frame_fifo #(
		.WIDTH(FRAME_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_frame_fifo (
		.clk(clk),
		.reset(reset),
		.port(fifoBus.store)
	);

	sector_state_t state;
	logic [4:0] framePos;
	logic [4:0] posNow;
	logic [FRAME_BITS-2:0] bitShift;
	logic sectorBad;
	logic isSyncSym;
	logic isDataSym;
	logic atSync;
	logic atData;
	logic locked;
	logic syncHit;
	logic syncMiss;
	logic symbolBad;
	logic frameDone;
	logic frameGood;
	logic [FRAME_BITS-1:0] frameWord;
	logic [3:0] relAddr;
	logic [7:0] userByte;

	logic inBlock;
	logic [3:0] expectRel;
	logic orderAcc;
	logic syncAcc;
	logic symbolAcc;
	logic [23:0] addrAcc;
	logic [7:0] classAcc;
	logic [47:0] infoAcc;
	logic prevValid;
	logic [23:0] prevAddr;
	logic blockStart;
	logic blockEnd;
	logic relInOrder;

	assign locked = (state == ST_LOCKED);
	assign isSyncSym = (pitBits[2:1] == SYM_SYNC_HEAD);
	assign isDataSym = (pitBits[2:1] == SYM_DATA_HEAD);
	assign posNow = (framePos == POS_LAST_FRAME) ? POS_SYNC
		: framePos + 5'h01;
	assign atSync = (posNow == POS_SYNC);
	assign atData = !posNow[0] && !atSync;

	// Sync is hunted only on a frame tick; once locked, a sync elsewhere does not reset phase.
	assign syncHit = !locked && frameTick && pitValid && isSyncSym;
	assign syncMiss = locked && frameTick && atSync
		&& !(pitValid && isSyncSym);

	// A symbol outside its slot, a lost one, or one off the frame tick.
	assign symbolBad = locked && ((frameTick && atData
		&& !(pitValid && isDataSym))
		|| (frameTick && posNow[0] && pitValid)
		|| (!frameTick && pitValid));

	assign frameDone = locked && frameTick && (posNow == POS_LAST_DATA);
	assign frameWord = {bitShift, pitBits[0]};
	assign frameGood = frameDone && !sectorBad && !symbolBad;
	assign relAddr = frameWord[REL_ADDR_MSB:REL_ADDR_LSB];
	assign userByte = frameWord[USER_BITS-1:0];

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ST_HUNT;
		end else if (syncHit) begin
			state <= ST_LOCKED;
		end else if (syncMiss) begin
			state <= ST_HUNT;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			framePos <= POS_SYNC;
		end else if (syncHit) begin
			framePos <= POS_SYNC;
		end else if (locked && frameTick) begin
			framePos <= posNow;
		end
	end

	// Placement is taken from each sector's sync, so either is accepted.
	always_ff @(posedge clk) begin
		if (reset) begin
			sectorOdd <= 1'b0;
		end else if (syncHit || (locked && frameTick && atSync
			&& pitValid && isSyncSym)) begin
			sectorOdd <= (pitBits == SYM_SYNC_ODD);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			bitShift <= '0;
		end else if (locked && frameTick && atData && pitValid) begin
			bitShift <= {bitShift[FRAME_BITS-3:0],
				pitBits == SYM_DATA_ONE};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sectorBad <= 1'b0;
		end else if (symbolBad) begin
			sectorBad <= 1'b1;
		end else if (syncHit || (locked && frameTick && atSync)) begin
			sectorBad <= 1'b0;
		end
	end

	// The disk cannot be stalled, so a full buffer drops the frame.
	assign fifoBus.wrValid = frameGood;
	assign fifoBus.wrData = frameWord;
	assign frameValid = fifoBus.rdValid;
	assign frameData = fifoBus.rdData;
	assign fifoBus.rdReady = frameReady;
	assign syncLocked = locked;

	always_ff @(posedge clk) begin
		if (reset) begin
			frameDropped <= 1'b0;
		end else begin
			frameDropped <= frameGood && !fifoBus.wrReady;
		end
	end

	assign blockStart = frameGood && (relAddr == REL_FIRST);
	assign relInOrder = (relAddr == expectRel);
	assign blockEnd = frameGood && inBlock && (relAddr == REL_LAST);

	always_ff @(posedge clk) begin
		if (reset) begin
			inBlock <= 1'b0;
			expectRel <= REL_FIRST;
		end else if (blockStart) begin
			inBlock <= 1'b1;
			expectRel <= relAddr + 4'h1;
		end else if (blockEnd) begin
			inBlock <= 1'b0;
			expectRel <= REL_FIRST;
		end else if (frameGood && inBlock) begin
			expectRel <= relAddr + 4'h1;
		end
	end

	// Error accumulators clear only on a good opening frame, never on an error.
	always_ff @(posedge clk) begin
		if (reset) begin
			orderAcc <= 1'b0;
		end else if (blockStart) begin
			orderAcc <= 1'b0;
		end else if (frameGood && inBlock && !relInOrder) begin
			orderAcc <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			syncAcc <= 1'b0;
		end else if (syncMiss) begin
			syncAcc <= 1'b1;
		end else if (blockStart) begin
			syncAcc <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			symbolAcc <= 1'b0;
		end else if (symbolBad || (frameDone && !frameGood)) begin
			symbolAcc <= 1'b1;
		end else if (blockStart) begin
			symbolAcc <= 1'b0;
		end
	end

	// Bytes are gathered by relative address; parity frames are only streamed.
	always_ff @(posedge clk) begin
		if (reset) begin
			addrAcc <= '0;
			classAcc <= '0;
			infoAcc <= '0;
		end else if (frameGood) begin
			if (relAddr <= REL_ADDR_LAST) begin
				addrAcc <= {addrAcc[15:0], userByte};
			end
			if (relAddr == REL_CLASS) begin
				classAcc <= userByte;
			end
			if (relAddr >= REL_INFO_FIRST && relAddr <= REL_INFO_LAST) begin
				infoAcc <= {infoAcc[39:0], userByte};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			blockDone <= 1'b0;
		end else begin
			blockDone <= blockEnd;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			blockAddress <= '0;
			blockClassCode <= '0;
			blockInfo <= '0;
			blockInDataZone <= 1'b0;
			blockOrderError <= 1'b0;
			blockSyncError <= 1'b0;
			blockSymbolError <= 1'b0;
			blockClassError <= 1'b0;
			blockStepError <= 1'b0;
		end else if (blockEnd) begin
			blockAddress <= addrAcc;
			blockClassCode <= classAcc;
			blockInfo <= infoAcc;
			blockInDataZone <= (addrAcc >= DATA_ZONE_START);
			blockOrderError <= orderAcc || !relInOrder;
			blockSyncError <= syncAcc;
			blockSymbolError <= symbolAcc;
			blockClassError <= (classAcc > CLASS_MAX);
			blockStepError <= prevValid
				&& (addrAcc != prevAddr + ADDR_STEP);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prevValid <= 1'b0;
			prevAddr <= '0;
		end else if (blockEnd) begin
			prevValid <= !(orderAcc || !relInOrder || syncAcc || symbolAcc);
			prevAddr <= addrAcc;
		end
	end

endmodule : land_prepit_block_deframer

// ---- land_prepit_block_deframer_properties.sv ----
// Port-level checks for the land pre-pit deframer.
`timescale 1ns/1ps
module land_prepit_block_deframer_properties
	import prepit_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Detector side
	input wire logic frameTick,
	input wire logic pitValid,
	input wire logic [2:0] pitBits,
	// Frame stream
	input wire logic frameValid,
	input wire logic frameReady,
	input wire logic [11:0] frameData,
	// Status and results
	input wire logic syncLocked,
	input wire logic sectorOdd,
	input wire logic blockDone,
	input wire logic [23:0] blockAddress,
	input wire logic [7:0] blockClassCode,
	input wire logic blockInDataZone,
	input wire logic blockClassError
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	AST_LOCK_ON_SYNC:
	assert property (!syncLocked && frameTick && pitValid &&
		pitBits[2:1] == SYM_SYNC_HEAD |=> syncLocked)
		else $error("sync symbol did not lock");
	AST_PLACEMENT:
	assert property (!syncLocked && frameTick && pitValid &&
		pitBits[2:1] == SYM_SYNC_HEAD |=> sectorOdd == !$past(pitBits[0]))
		else $error("placement flag wrong");
	AST_LOCK_HOLD:
	assert property (syncLocked && !frameTick |=> syncLocked)
		else $error("lock lost without a tick");
	AST_PUSH_ON_TICK:
	assert property ($rose(frameValid) |-> $past(frameTick) && syncLocked)
		else $error("frame appeared off a tick");
	AST_HEAD_HOLD:
	assert property (frameValid && !frameReady |=>
		frameValid && $stable(frameData))
		else $error("head word changed while stalled");
	AST_DONE_PULSE:
	assert property (blockDone |=> !blockDone [*8])
		else $error("block done too close");
	AST_ZONE:
	assert property (blockDone |->
		blockInDataZone == (blockAddress >= DATA_ZONE_START))
		else $error("data zone flag wrong");
	AST_CLASS:
	assert property (blockDone |->
		blockClassError == (blockClassCode > CLASS_MAX))
		else $error("class flag wrong");
	AST_RESULT_HOLD:
	assert property (!blockDone |-> $stable(blockAddress) &&
		$stable(blockClassCode))
		else $error("block result changed without done");
endmodule : land_prepit_block_deframer_properties

bind land_prepit_block_deframer land_prepit_block_deframer_properties
	u_props (.clk, .reset, .frameTick, .pitValid, .pitBits, .frameValid,
	.frameReady, .frameData, .syncLocked, .sectorOdd, .blockDone,
	.blockAddress, .blockClassCode, .blockInDataZone, .blockClassError);

// ---- prepit_detector_model.sv ----
// Behavioural pre-pit detector that plays sectors into the deframer.
`timescale 1ns/1ps
module prepit_detector_model
	import prepit_pkg::*;
(
	// Clock
	input wire logic clk,
	// Detector outputs
	output logic frameTick,
	output logic pitValid,
	output logic [2:0] pitBits
);
	initial begin
		frameTick = 1'b0;
		pitValid = 1'b0;
		pitBits = 3'h0;
	end

	// Idle cycles toggle the bits so a stale symbol is never mistaken.
	// A spoiled sector carries a stray symbol in its first odd slot.
	task automatic send_sector(input logic [11:0] w, input logic odd,
		input logic noSync, input logic spoil);
		int p;
		for (p = 0; p < 26; p++) begin
			@(posedge clk);
			#1;
			frameTick = 1'b1;
			pitValid = !p[0] || (p == 1 && spoil);
			if (p == 0)
				pitBits = noSync ? SYM_DATA_ONE : {SYM_SYNC_HEAD, !odd};
			else if (!p[0])
				pitBits = w[12 - p / 2] ? SYM_DATA_ONE : SYM_DATA_ZERO;
			else
				pitBits = ~pitBits;
			@(posedge clk);
			#1;
			frameTick = 1'b0;
			pitValid = 1'b0;
			pitBits = ~pitBits;
		end
	endtask : send_sector
endmodule : prepit_detector_model

// ---- land_prepit_block_deframer_tb.sv ----
// Self-checking testbench for the land pre-pit deframer.
`timescale 1ns/1ps
module land_prepit_block_deframer_tb
	import prepit_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic frameReady = 1'b1;
	logic frameTick, pitValid, frameValid, frameDropped, syncLocked;
	logic sectorOdd, blockDone, blockInDataZone, blockOrderError;
	logic blockSyncError, blockSymbolError, blockClassError, blockStepError;
	logic [2:0] pitBits;
	logic [11:0] frameData;
	logic [23:0] blockAddress;
	logic [7:0] blockClassCode;
	logic [47:0] blockInfo;
	logic [11:0] expQ[$];
	int n_fail = 0;
	int n_compared = 0;
	int nDone = 0;
	int nDrop = 0;
	int cyc = 0;

	always #12.5 clk = ~clk;

	land_prepit_block_deframer dut (.clk, .reset, .frameTick, .pitValid,
		.pitBits, .frameValid, .frameReady, .frameData, .frameDropped,
		.syncLocked, .sectorOdd, .blockDone, .blockAddress, .blockClassCode,
		.blockInfo, .blockInDataZone, .blockOrderError, .blockSyncError,
		.blockSymbolError, .blockClassError, .blockStepError);
	prepit_detector_model det (.clk, .frameTick, .pitValid, .pitBits);

	task automatic stop_test;
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test

	task automatic compare(input logic [47:0] got, input logic [47:0] exp,
		input string what);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h", $time, what, got);
		end
	endtask : compare

	always @(posedge clk) begin
		cyc++;
		if (blockDone === 1'b1)
			nDone++;
		if (frameDropped === 1'b1)
			nDrop++;
		if (frameValid === 1'b1 && frameReady === 1'b1)
			compare(frameData, expQ.size() ? expQ.pop_front() : 12'hx,
				"frame");
		if (cyc == 7000) begin
			n_fail++;
			stop_test();
		end
	end

	// Parity bytes are filler; they are checked only as streamed frame words.
	// Words are queued before the sector is played, because the head word
	// is taken while the sector's last sync frame is still running.
	task automatic send_block(input logic [23:0] a, input logic [7:0] c,
		input logic odd, input int skip, input int lose, input int spoil);
		int d;
		int f;
		logic [11:0] w;
		d = nDone;
		for (f = 0; f < 16; f++) begin
			w[7:0] = f < 3 ? a[23 - 8 * f -: 8] : (f == 6 ? c : 8'(f * 17));
			w[11:8] = 4'(f == skip ? f + 1 : f);
			if (f != lose && f != spoil)
				expQ.push_back(w);
			det.send_sector(w, odd, f == lose, f == spoil);
		end
		compare(nDone - d, 1, "done count");
	endtask : send_block

	task automatic check_block(input logic [23:0] a, input logic [7:0] c,
		input logic [5:0] flags);
		compare(blockAddress, a, "address");
		compare(blockClassCode, c, "class");
		compare({blockInDataZone, blockOrderError, blockSyncError,
			blockSymbolError, blockClassError, blockStepError}, flags,
			"flags");
	endtask : check_block

	task automatic test_even;
		send_block(24'h003000, 8'h00, 1'b0, 99, 99, 99);
		compare(sectorOdd, 0, "placement");
		compare(syncLocked, 1, "lock");
		compare(blockInfo, 48'h778899aabbcc, "info");
		check_block(24'h003000, 8'h00, 6'h20);
		$display("test even block done");
	endtask : test_even

	task automatic test_odd_step;
		send_block(24'h003001, 8'h05, 1'b1, 99, 99, 99);
		compare(sectorOdd, 1, "placement");
		check_block(24'h003001, 8'h05, 6'h20);
		send_block(24'h002fff, 8'h06, 1'b0, 99, 99, 99);
		check_block(24'h002fff, 8'h06, 6'h03);
		$display("test placement and step done");
	endtask : test_odd_step

	task automatic test_faults;
		send_block(24'h003000, 8'h00, 1'b0, 5, 99, 99);
		compare(blockOrderError, 1, "order");
		send_block(24'h003000, 8'h00, 1'b0, 99, 9, 99);
		compare({blockOrderError, blockSyncError}, 2'h3, "sync");
		send_block(24'h003000, 8'h00, 1'b0, 99, 99, 4);
		compare({blockOrderError, blockSyncError, blockSymbolError}, 3'h5,
			"symbol");
		$display("test faults done");
	endtask : test_faults

	task automatic test_fifo;
		int d;
		int f;
		d = nDrop;
		frameReady = 1'b0;
		for (f = 0; f < 5; f++) begin
			det.send_sector({4'h0, 8'(f)}, 1'b0, 1'b0, 1'b0);
			if (f < FIFO_DEPTH)
				expQ.push_back({4'h0, 8'(f)});
		end
		compare(nDrop - d, 1, "drops");
		compare(frameValid, 1, "full");
		frameReady = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		compare(frameValid, 0, "empty");
		compare(expQ.size(), 0, "drained");
		$display("test buffer full done");
	endtask : test_fifo

	initial begin
		repeat (6) @(posedge clk);
		#1;
		reset = 1'b0;
		test_even();
		test_odd_step();
		test_faults();
		test_fifo();
		stop_test();
	end
endmodule : land_prepit_block_deframer_tb
